// >>> hdl/sccr_pkg.sv
// constants and carrier types for the system control coprocessor registers
package sccr_pkg;

	// ****************************************
	// coprocessor register selectors
	// ****************************************
	localparam logic [3:0] CRN_CONTROL = 4'h1;
	localparam logic [3:0] CRN_CORE_CTRL = 4'h7;
	localparam logic [3:0] CRN_TRACE = 4'hD;
	localparam logic [3:0] CRN_UNDEF = 4'hE;
	localparam logic [3:0] CRN_LEGACY = 4'hF;
	localparam logic [3:0] CRM_DRAIN = 4'hA;
	localparam logic [3:0] CRM_WAIT = 4'h0;
	localparam logic [3:0] CRM_LEGACY_WAIT = 4'h8;
	localparam logic [3:0] CRM_TRACE = 4'h1;
	localparam logic [3:0] CRM_CONTROL = 4'h0;
	localparam logic [2:0] OPC1_SYS = 3'h0;
	localparam logic [2:0] OPC2_DRAIN = 3'h4;
	localparam logic [2:0] OPC2_WAIT = 3'h4;
	localparam logic [2:0] OPC2_LEGACY_WAIT = 3'h2;
	localparam logic [2:0] OPC2_TRACE = 3'h1;
	localparam logic [2:0] OPC2_CONTROL = 3'h0;

	// ****************************************
	// control register field positions
	// ****************************************
	localparam int BIT_LOAD_PC_SWITCH_DIS = 15;
	localparam int BIT_VECTOR_HIGH = 13;
	localparam int BIT_INSTR_RAM = 12;
	localparam int BIT_BIG_ENDIAN = 7;
	localparam int BIT_WRITE_BUFFER = 3;
	localparam int BIT_DATA_TO_BUS = 2;

	// ****************************************
	// reset values and vector bases
	// ****************************************
	localparam logic RST_LOAD_PC_SWITCH_DIS = 1'b0;
	localparam logic RST_BIG_ENDIAN = 1'b0;
	localparam logic RST_WRITE_BUFFER = 1'b0;
	localparam logic [31:0] VECTOR_BASE_LOW = 32'h00000000;
	localparam logic [31:0] VECTOR_BASE_HIGH = 32'hFFFF0000;
	localparam logic [31:0] TRACE_ID_RESET = 32'h00000000;
	localparam logic [31:0] READ_FILLER = 32'h00000000;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic valid;
		logic write;
		logic user_mode;
		logic [2:0] opc1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] opc2;
		logic [31:0] wdata;
	} sccr_req_t;

	typedef struct packed {
		logic done;
		logic undef;
		logic [31:0] rdata;
	} sccr_resp_t;

	typedef struct packed {
		logic load_pc_switch_dis;
		logic vector_high;
		logic instr_ram_on;
		logic big_endian;
		logic write_buffer_on;
		logic data_to_bus;
	} sccr_ctrl_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DRAIN,
		ST_WAIT
	} sccr_state_t;

endpackage

// >>> hdl/sccr_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module sccr_sync
#(
	parameter int W = 8
)
(
	input wire logic sys_clk,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] hold_q;

	// no reset here so straps are already settled when reset samples them
	always_ff @(posedge sys_clk)
	begin
		meta_q <= pin_in;
		hold_q <= meta_q;
	end

	assign level_out = hold_q;
endmodule // sccr_sync
`default_nettype wire

// >>> hdl/sccr_core.sv
// system control coprocessor register logic: control, core control and trace id
// Functional notes
// - load-pc bit 0 picks compressed state unless switch-disable bit set; resets clear
// - vector select bit 13 read-only; base 0 or FFFF0000; reset from init pin
// - instruction ram bit 12 routes instruction space to ram; reset from pin
// - endian bit 7: 0 little, 1 big; cleared at reset
// - write buffer bit 3 enables write buffer when set
// - core control register write-only; reads unspecified; writes trigger operations
// - c7,c10,4 write stalls core until write buffer fully drained
// - wait-for-interrupt drops core clock gate enable until interrupt or debug
// - wait triggered by c7,c0,4 and legacy c15,c8,2
// - wait ends on fast, normal interrupt, external or debugger debug request
// - interrupt wakeup ignores the status word interrupt disable bits
// - debug wakeup only while debug enable input set
// - enabled interrupt taken first; disabled resumes at next instruction
// - debug wakeup enters debug state before any further instruction
// - write buffer keeps draining during wait standby
// - trace process id driven continuously on 32-bit output
// - each trace id write pulses strobe for exactly one cycle
// - control bits reset to zero unless given another reset value
// - user mode access takes undefined instruction trap
// - trace id reached at c13, c1, opcode 1
`timescale 1ns/1ps
`default_nettype none
module sccr_core
	import sccr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire sccr_req_t cp_req,
	input wire logic pc_load_valid,
	input wire logic pc_load_bit0,
	input wire logic psr_irq_disable,
	input wire logic psr_fiq_disable,
	input wire logic write_buffer_empty,
	input wire logic vector_high_init_pin,
	input wire logic instr_ram_init_pin,
	input wire logic data_bus_init_pin,
	input wire logic fast_int_request_n,
	input wire logic normal_int_request_n,
	input wire logic external_debug_request,
	input wire logic debugger_request_bit,
	input wire logic debug_enable_input,
	output var sccr_resp_t cp_resp,
	output var sccr_ctrl_t ctrl,
	output logic [31:0] vector_base,
	output logic enter_compressed,
	output logic core_stall,
	output logic core_clock_gate_enable,
	output logic take_interrupt,
	output logic resume_next,
	output logic enter_debug,
	output logic [31:0] trace_process_id_out,
	output logic trace_process_id_write_strobe
);

	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [7:0] pins_s;
	logic vhi_s, iram_s, dbus_s, fiq_n_s, irq_n_s, edbg_s, dbit_s, dben_s;

	sccr_sync #(.W(8)) u_sync
	(
		.sys_clk(sys_clk),
		.pin_in({vector_high_init_pin, instr_ram_init_pin, data_bus_init_pin, fast_int_request_n,
			normal_int_request_n, external_debug_request, debugger_request_bit, debug_enable_input}),
		.level_out(pins_s)
	);

	assign {vhi_s, iram_s, dbus_s, fiq_n_s, irq_n_s, edbg_s, dbit_s, dben_s} = pins_s;

	// ****************************************
	// request decode
	// ****************************************
	function automatic logic hit(input sccr_req_t r, input logic [3:0] n, input logic [3:0] m,
		input logic [2:0] o2);
		hit = (r.opc1 == OPC1_SYS) && (r.crn == n) && (r.crm == m) && (r.opc2 == o2);
	endfunction

	sccr_state_t st_q, st_d;
	logic take, user_trap, wr_ok, ctrl_wr, trace_wr, drain_go, wait_go;

	// requests are only taken while the core is running
	assign take = cp_req.valid && (st_q == ST_RUN);
	assign user_trap = take && (cp_req.user_mode || cp_req.crn == CRN_UNDEF);
	assign wr_ok = take && !user_trap && cp_req.write;
	assign ctrl_wr = wr_ok && hit(cp_req, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL);
	assign trace_wr = wr_ok && hit(cp_req, CRN_TRACE, CRM_TRACE, OPC2_TRACE);
	assign drain_go = wr_ok && hit(cp_req, CRN_CORE_CTRL, CRM_DRAIN, OPC2_DRAIN);
	// both wait encodings lead to the same standby
	assign wait_go = wr_ok && (hit(cp_req, CRN_CORE_CTRL, CRM_WAIT, OPC2_WAIT) ||
		hit(cp_req, CRN_LEGACY, CRM_LEGACY_WAIT, OPC2_LEGACY_WAIT));

	// ****************************************
	// wakeup decode
	// ****************************************
	logic int_wake, dbg_wake, wake, int_enabled;

	// interrupt wake ignores the status word mask bits
	assign int_wake = !fiq_n_s || !irq_n_s;
	// debug wake needs debug enabled
	assign dbg_wake = dben_s && (edbg_s || dbit_s);
	assign wake = int_wake || dbg_wake;
	assign int_enabled = (!fiq_n_s && !psr_fiq_disable) || (!irq_n_s && !psr_irq_disable);

	// ****************************************
	// operation sequencer
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_RUN:
			begin
				if (drain_go)
					st_d = ST_DRAIN;
				else if (wait_go)
					st_d = ST_WAIT;
			end
			ST_DRAIN:
			begin
				if (write_buffer_empty)
					st_d = ST_RUN;
			end
			ST_WAIT:
			begin
				if (wake)
					st_d = ST_RUN;
			end
			default:
				st_d = ST_RUN;
		endcase
	end

	logic done_d;
	assign done_d = (take && !drain_go && !wait_go) || (st_q != ST_RUN && st_d == ST_RUN);

	// ****************************************
	// read data select
	// ****************************************
	sccr_ctrl_t ctrl_q;
	logic [31:0] trace_q, ctrl_rd, rdata_d;

	// reserved bits read as zero
	always_comb
	begin
		ctrl_rd = READ_FILLER;
		ctrl_rd[BIT_LOAD_PC_SWITCH_DIS] = ctrl_q.load_pc_switch_dis;
		ctrl_rd[BIT_VECTOR_HIGH] = ctrl_q.vector_high;
		ctrl_rd[BIT_INSTR_RAM] = ctrl_q.instr_ram_on;
		ctrl_rd[BIT_BIG_ENDIAN] = ctrl_q.big_endian;
		ctrl_rd[BIT_WRITE_BUFFER] = ctrl_q.write_buffer_on;
		ctrl_rd[BIT_DATA_TO_BUS] = ctrl_q.data_to_bus;
	end

	// the write-only core control register reads back the filler
	assign rdata_d = (hit(cp_req, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL)) ? ctrl_rd :
		(hit(cp_req, CRN_TRACE, CRM_TRACE, OPC2_TRACE)) ? trace_q : READ_FILLER;

	// ****************************************
	// control register
	// ****************************************
	// the vector bit is never written, only loaded from its strap
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctrl_q.load_pc_switch_dis <= RST_LOAD_PC_SWITCH_DIS;
			ctrl_q.vector_high <= vhi_s;
			ctrl_q.instr_ram_on <= iram_s;
			ctrl_q.big_endian <= RST_BIG_ENDIAN;
			ctrl_q.write_buffer_on <= RST_WRITE_BUFFER;
			ctrl_q.data_to_bus <= dbus_s;
		end
		else if (ctrl_wr)
		begin
			ctrl_q.load_pc_switch_dis <= cp_req.wdata[BIT_LOAD_PC_SWITCH_DIS];
			ctrl_q.instr_ram_on <= cp_req.wdata[BIT_INSTR_RAM];
			ctrl_q.big_endian <= cp_req.wdata[BIT_BIG_ENDIAN];
			ctrl_q.write_buffer_on <= cp_req.wdata[BIT_WRITE_BUFFER];
			ctrl_q.data_to_bus <= cp_req.wdata[BIT_DATA_TO_BUS];
		end
	end

	// ****************************************
	// trace id and answer registers
	// ****************************************
	sccr_resp_t resp_q;
	logic strobe_q, compressed_q;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			trace_q <= TRACE_ID_RESET;
			strobe_q <= 1'b0;
			resp_q <= '0;
			compressed_q <= 1'b0;
		end
		else
		begin
			if (trace_wr)
				trace_q <= cp_req.wdata;
			strobe_q <= trace_wr;
			resp_q.done <= done_d;
			resp_q.undef <= user_trap;
			resp_q.rdata <= (take && !cp_req.write && !user_trap) ? rdata_d : READ_FILLER;
			compressed_q <= pc_load_valid && pc_load_bit0 && !ctrl_q.load_pc_switch_dis;
		end
	end

	// ****************************************
	// stall, clock gate and wake outcome
	// ****************************************
	logic stall_q, gate_q, take_int_q, resume_q, debug_q;
	logic [31:0] vbase_q;
	logic leave_wait;

	assign leave_wait = (st_q == ST_WAIT) && wake;

	// write buffer is not gated here so it keeps draining in standby
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_q <= ST_RUN;
			stall_q <= 1'b0;
			gate_q <= 1'b1;
			take_int_q <= 1'b0;
			resume_q <= 1'b0;
			debug_q <= 1'b0;
			vbase_q <= VECTOR_BASE_LOW;
		end
		else
		begin
			st_q <= st_d;
			stall_q <= (st_d != ST_RUN);
			gate_q <= (st_d != ST_WAIT);
			debug_q <= leave_wait && dbg_wake;
			take_int_q <= leave_wait && !dbg_wake && int_enabled;
			resume_q <= leave_wait && !dbg_wake && !int_enabled;
			vbase_q <= ctrl_q.vector_high ? VECTOR_BASE_HIGH : VECTOR_BASE_LOW;
		end
	end

	assign cp_resp = resp_q;
	assign ctrl = ctrl_q;
	assign vector_base = vbase_q;
	assign enter_compressed = compressed_q;
	assign core_stall = stall_q;
	assign core_clock_gate_enable = gate_q;
	assign take_interrupt = take_int_q;
	assign resume_next = resume_q;
	assign enter_debug = debug_q;
	assign trace_process_id_out = trace_q;
	assign trace_process_id_write_strobe = strobe_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_drain_start;
		drain_go ##1 (st_q == ST_DRAIN);
	endsequence

	property p_switch_load;
		pc_load_valid && pc_load_bit0 && !ctrl_q.load_pc_switch_dis |=> enter_compressed;
	endproperty
	a_switch_load: assert property (p_switch_load) else $error("compressed entry missed");

	property p_vector_fixed;
		ctrl_wr |=> $stable(ctrl_q.vector_high) ##1 (vector_base == $past(vector_base));
	endproperty
	a_vector_fixed: assert property (p_vector_fixed) else $error("vector bit moved on write");

	property p_iram_write;
		ctrl_wr |=> ctrl.instr_ram_on == $past(cp_req.wdata[BIT_INSTR_RAM]);
	endproperty
	a_iram_write: assert property (p_iram_write) else $error("instruction ram bit not written");

	property p_endian_write;
		ctrl_wr |=> ctrl.big_endian == $past(cp_req.wdata[BIT_BIG_ENDIAN]);
	endproperty
	a_endian_write: assert property (p_endian_write) else $error("endian bit not written");

	property p_drain_stall;
		s_drain_start |-> core_stall;
	endproperty
	a_drain_stall: assert property (p_drain_stall) else $error("drain did not stall");

	property p_drain_hold;
		(st_q == ST_DRAIN) && !write_buffer_empty |=> core_stall && !cp_resp.done;
	endproperty
	a_drain_hold: assert property (p_drain_hold) else $error("drain released early");

	property p_wait_gate;
		wait_go |=> !core_clock_gate_enable && core_stall && $stable(ctrl.write_buffer_on);
	endproperty
	a_wait_gate: assert property (p_wait_gate) else $error("clock gate kept on in wait");

	property p_int_wake;
		(st_q == ST_WAIT) && !irq_n_s |=> core_clock_gate_enable && cp_resp.done;
	endproperty
	a_int_wake: assert property (p_int_wake) else $error("interrupt did not wake");

	property p_no_debug_wake;
		(st_q == ST_WAIT) && fiq_n_s && irq_n_s && !dben_s |=> !core_clock_gate_enable;
	endproperty
	a_no_debug_wake: assert property (p_no_debug_wake) else $error("woke without cause");

	property p_debug_first;
		leave_wait && dbg_wake |=> enter_debug && !take_interrupt && !resume_next;
	endproperty
	a_debug_first: assert property (p_debug_first) else $error("debug wake not to debug");

	property p_strobe_one;
		trace_wr ##1 !trace_wr |-> trace_process_id_write_strobe ##1 !trace_process_id_write_strobe;
	endproperty
	a_strobe_one: assert property (p_strobe_one) else $error("strobe width wrong");

	property p_trace_out;
		trace_wr |=> trace_process_id_out == $past(cp_req.wdata);
	endproperty
	a_trace_out: assert property (p_trace_out) else $error("trace id output wrong");

	property p_user_trap;
		take && cp_req.user_mode |=> cp_resp.undef && cp_resp.done;
	endproperty
	a_user_trap: assert property (p_user_trap) else $error("user access not trapped");

endmodule // sccr_core
`default_nettype wire

// >>> verif/sccr_cpu_model.sv
// pipeline model that issues coprocessor transfers and collects the answers
`timescale 1ns/1ps
`default_nettype none
module sccr_cpu_model
	import sccr_pkg::*;
(
	input wire logic sys_clk,
	input wire sccr_resp_t cp_resp,
	input wire logic [2:0] wake_seen,
	output var sccr_req_t cp_req
);
	logic [31:0] rdata_q;
	logic [31:0] lat_q;
	logic undef_q;
	logic hang_q;
	logic [2:0] wake_q;

	// idle request at time zero
	initial
	begin
		cp_req = '0;
	end

	// valid lasts one cycle: a held valid would be taken again once idle
	task automatic send(input sccr_req_t r);
		sccr_req_t m;
		m = r;
		if (r.write && r.crn == CRN_CONTROL)
			m.wdata = (r.wdata & 32'h0000B08C) | 32'h00000070;
		@(posedge sys_clk);
		#1;
		cp_req = m;
		@(posedge sys_clk);
		#1;
		cp_req.valid = 1'b0;
	endtask

	// bounded wait for done, capture everything that stands with it
	task automatic wait_done(input int max);
		int n;
		n = 0;
		while (cp_resp.done !== 1'b1 && n < max)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		hang_q = (cp_resp.done !== 1'b1);
		lat_q = n;
		rdata_q = cp_resp.rdata;
		undef_q = cp_resp.undef;
		wake_q = wake_seen;
	endtask
endmodule // sccr_cpu_model
`default_nettype wire

// >>> verif/system_control_coprocessor_regs_tb.sv
// self-checking bench for the system control coprocessor registers
`timescale 1ns/1ps
`default_nettype none
module system_control_coprocessor_regs_tb;
	import sccr_pkg::*;
	logic sys_clk, rst, pc_load_valid, pc_load_bit0, psr_irq_disable, psr_fiq_disable, write_buffer_empty;
	logic vector_high_init_pin, instr_ram_init_pin, data_bus_init_pin, fast_int_request_n, normal_int_request_n;
	logic external_debug_request, debugger_request_bit, debug_enable_input, enter_compressed, core_stall;
	logic core_clock_gate_enable, take_interrupt, resume_next, enter_debug, trace_process_id_write_strobe;
	logic [31:0] vector_base, trace_process_id_out;
	sccr_req_t cp_req;
	sccr_resp_t cp_resp;
	sccr_ctrl_t ctrl;
	int fails, check_count, cycles;

	sccr_core dut_u (.sys_clk, .rst, .cp_req, .pc_load_valid, .pc_load_bit0, .psr_irq_disable, .psr_fiq_disable,
		.write_buffer_empty, .vector_high_init_pin, .instr_ram_init_pin, .data_bus_init_pin, .fast_int_request_n,
		.normal_int_request_n, .external_debug_request, .debugger_request_bit, .debug_enable_input, .cp_resp, .ctrl,
		.vector_base, .enter_compressed, .core_stall, .core_clock_gate_enable, .take_interrupt, .resume_next,
		.enter_debug, .trace_process_id_out, .trace_process_id_write_strobe);
	sccr_cpu_model cpu_u (.sys_clk, .cp_resp, .wake_seen({take_interrupt, resume_next, enter_debug}), .cp_req);

	// ****************************************
	// clock, hang guard, compares
	// ****************************************
	always #50 sys_clk = ~sys_clk;

	// whole run is about 130 cycles; far above that means a hang
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			final_report();
		end
	end

	task automatic final_report();
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s exp %b got %b", what, exp, got);
		end
	endtask

	task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	function automatic sccr_req_t mk(input logic w, input logic u, input logic [3:0] crn, input logic [3:0] crm,
		input logic [2:0] o2, input logic [31:0] wd);
		mk = '{valid: 1'b1, write: w, user_mode: u, opc1: OPC1_SYS, crn: crn, crm: crm, opc2: o2, wdata: wd};
	endfunction

	task automatic op(input logic w, input logic u, input logic [3:0] crn, input logic [3:0] crm,
		input logic [2:0] o2, input logic [31:0] wd);
		cpu_u.send(mk(w, u, crn, crm, o2, wd));
		cpu_u.wait_done(4);
		chk32("latency", 32'h00000000, cpu_u.lat_q);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	// straps all high so that a plain reset-to-zero shows up
	task automatic t_reset();
		step(1);
		chk32("ctrl_rst", 32'h00000019, {26'h0, ctrl});
		chk32("vbase_rst", 32'hFFFF0000, vector_base);
		chk32("tid_rst", 32'h00000000, trace_process_id_out);
		chk1("gate_rst", 1'b1, core_clock_gate_enable);
	endtask

	task automatic pcl(input logic exp);
		pc_load_valid = 1'b1;
		pc_load_bit0 = 1'b1;
		step(1);
		chk1("compressed", exp, enter_compressed);
		pc_load_valid = 1'b0;
	endtask

	// vector bit must not follow a write of zero while its strap holds it high
	task automatic t_control();
		op(1'b1, 1'b0, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'hFFFFFFFF);
		chk32("ctrl_ones", 32'h0000003F, {26'h0, ctrl});
		pcl(1'b0);
		op(1'b0, 1'b0, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'h0);
		chk32("rd_ones", 32'h0000B08C, cpu_u.rdata_q);
		op(1'b1, 1'b0, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'h0);
		chk32("ctrl_zero", 32'h00000010, {26'h0, ctrl});
		pcl(1'b1);
		op(1'b0, 1'b0, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'h0);
		chk32("rd_zero", 32'h00002000, cpu_u.rdata_q);
		chk32("vbase", 32'hFFFF0000, vector_base);
	endtask

	task automatic t_trace();
		op(1'b1, 1'b0, CRN_TRACE, CRM_TRACE, OPC2_TRACE, 32'hA5C30F96);
		chk1("strobe_hi", 1'b1, trace_process_id_write_strobe);
		step(1);
		chk1("strobe_lo", 1'b0, trace_process_id_write_strobe);
		chk32("tid", 32'hA5C30F96, trace_process_id_out);
		op(1'b0, 1'b0, CRN_TRACE, CRM_TRACE, OPC2_TRACE, 32'h0);
		chk32("tid_rd", 32'hA5C30F96, cpu_u.rdata_q);
	endtask

	// trapped accesses leave the control register alone
	task automatic t_trap();
		op(1'b1, 1'b1, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'hFFFFFFFF);
		chk1("undef_user", 1'b1, cpu_u.undef_q);
		chk32("ctrl_kept", 32'h00000010, {26'h0, ctrl});
		op(1'b1, 1'b0, CRN_UNDEF, CRM_CONTROL, OPC2_CONTROL, 32'h0);
		chk1("undef_c14", 1'b1, cpu_u.undef_q);
		op(1'b0, 1'b0, CRN_CORE_CTRL, CRM_WAIT, OPC2_WAIT, 32'h0);
		chk1("c7_read", 1'b0, cpu_u.undef_q);
	endtask

	task automatic t_drain();
		write_buffer_empty = 1'b0;
		cpu_u.send(mk(1'b1, 1'b0, CRN_CORE_CTRL, CRM_DRAIN, OPC2_DRAIN, 32'h0));
		step(3);
		chk1("drain_stall", 1'b1, core_stall);
		chk1("drain_busy", 1'b0, cp_resp.done);
		write_buffer_empty = 1'b1;
		cpu_u.wait_done(4);
		chk1("drain_hang", 1'b0, cpu_u.hang_q);
		chk1("drain_free", 1'b0, core_stall);
		op(1'b1, 1'b0, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'h00000008);
		chk1("wb_on", 1'b1, ctrl.write_buffer_on);
	endtask

	// src bits: fast, normal, external debug, debugger bit; exp 0 = no wake
	task automatic wt(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] o2, input logic [3:0] src,
		input logic [2:0] exp);
		cpu_u.send(mk(1'b1, 1'b0, crn, crm, o2, 32'h0));
		write_buffer_empty = 1'b0;
		step(4);
		chk1("wait_gate", 1'b0, core_clock_gate_enable);
		chk1("wait_stall", 1'b1, core_stall);
		chk1("wait_wb", 1'b1, ctrl.write_buffer_on);
		{fast_int_request_n, normal_int_request_n, external_debug_request, debugger_request_bit} = src ^ 4'hC;
		cpu_u.wait_done(6);
		chk1("wait_hang", exp == 3'h0, cpu_u.hang_q);
		if (exp == 3'h0)
		begin
			normal_int_request_n = 1'b0;
			cpu_u.wait_done(6);
		end
		chk32("wake", {29'h0, (exp == 3'h0) ? 3'h2 : exp}, {29'h0, cpu_u.wake_q});
		chk1("wake_gate", 1'b1, core_clock_gate_enable);
		{fast_int_request_n, normal_int_request_n, external_debug_request, debugger_request_bit} = 4'hC;
		write_buffer_empty = 1'b1;
		step(4);
	endtask

	// mid-run reset with straps low: strap bits, vector base and trace id all fall back
	task automatic t_rerun();
		rst = 1'b1;
		{vector_high_init_pin, instr_ram_init_pin, data_bus_init_pin} = 3'h0;
		step(4);
		rst = 1'b0;
		step(1);
		chk32("ctrl_rerun", 32'h00000000, {26'h0, ctrl});
		chk32("vbase_low", 32'h00000000, vector_base);
		chk32("tid_rerun", 32'h00000000, trace_process_id_out);
		chk1("stall_rerun", 1'b0, core_stall);
		op(1'b0, 1'b0, CRN_CONTROL, CRM_CONTROL, OPC2_CONTROL, 32'h0);
		chk32("rd_rerun", 32'h00000000, cpu_u.rdata_q);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		pc_load_valid = 1'b0;
		pc_load_bit0 = 1'b0;
		psr_irq_disable = 1'b1;
		psr_fiq_disable = 1'b1;
		write_buffer_empty = 1'b1;
		{vector_high_init_pin, instr_ram_init_pin, data_bus_init_pin} = 3'h7;
		{fast_int_request_n, normal_int_request_n, external_debug_request, debugger_request_bit} = 4'hC;
		debug_enable_input = 1'b0;
		repeat (20) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_control();
		t_trace();
		t_trap();
		t_drain();
		wt(CRN_CORE_CTRL, CRM_WAIT, OPC2_WAIT, 4'h4, 3'h2);
		psr_fiq_disable = 1'b0;
		wt(CRN_LEGACY, CRM_LEGACY_WAIT, OPC2_LEGACY_WAIT, 4'h8, 3'h4);
		wt(CRN_CORE_CTRL, CRM_WAIT, OPC2_WAIT, 4'h2, 3'h0);
		debug_enable_input = 1'b1;
		wt(CRN_CORE_CTRL, CRM_WAIT, OPC2_WAIT, 4'h2, 3'h1);
		wt(CRN_LEGACY, CRM_LEGACY_WAIT, OPC2_LEGACY_WAIT, 4'h1, 3'h1);
		t_rerun();
		final_report();
	end
endmodule // system_control_coprocessor_regs_tb
`default_nettype wire
